// >>> common/fsq_pkg.sv
// Shared constants and types for the serial flash program/erase sequencer
package fsq_pkg;

  // Array geometry; address bits above ADDR_W are ignored
  localparam int ADDR_W     = 19;
  localparam int PAGE_W     = 8;
  localparam int SUB_W      = 12;
  localparam int SECT_LSB   = 16;
  localparam int SECT_W     = 3;
  localparam int NUM_SECT   = 8;
  localparam int MEM_BYTES  = 1 << ADDR_W;
  localparam int PAGE_BYTES = 1 << PAGE_W;
  localparam logic [SUB_W-1:0] PAGE_LAST = 12'h0ff;
  localparam logic [SUB_W-1:0] SUB_LAST  = 12'hfff;
  localparam logic [7:0]       BYTE_ERASED = 8'hff;

  // Command opcodes, most significant bit first on the link
  localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OPC_PROGRAM_PAGE = 8'h02;
  localparam logic [7:0] OPC_LOCK_WRITE   = 8'he5;
  localparam logic [7:0] OPC_ERASE_PAGE   = 8'hdb;
  localparam logic [7:0] OPC_ERASE_SUB    = 8'h20;

  // Byte counts seen in a frame (saturating)
  localparam logic [2:0] NB_OPCODE = 3'd1;
  localparam logic [2:0] NB_ADDR   = 3'd4;
  localparam logic [2:0] NB_DATA1  = 3'd5;
  localparam logic [2:0] NB_MAX    = 3'd6;
  localparam logic [2:0] BIT_LAST  = 3'd7;

  // Lock byte fields
  localparam int LOCK_DOWN_BIT = 1;
  localparam int LOCK_WR_BIT   = 0;

  // Self-timed cycle durations
  localparam int CLK_MHZ            = 50;
  localparam int PROG_TIME_US       = 800;
  localparam int PAGE_ERASE_TIME_US = 10000;
  localparam int SUB_ERASE_TIME_US  = 80000;
  localparam int PROG_CYC_DEF   = PROG_TIME_US * CLK_MHZ;
  localparam int PERASE_CYC_DEF = PAGE_ERASE_TIME_US * CLK_MHZ;
  localparam int SSE_CYC_DEF    = SUB_ERASE_TIME_US * CLK_MHZ;
  localparam int TMR_W          = 24;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [2:0]  nbytes;
    logic        aligned;
    logic        open;
    logic [7:0]  lock_data;
  } fsq_frame_t;

  typedef struct packed {
    logic down;
    logic wlock;
  } fsq_lock_t;

  typedef struct packed {
    logic accepted;
    logic busy;
    logic no_wel;
    logic protect;
    logic framing;
  } fsq_result_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WORK = 3'b010,
    ST_WAIT = 3'b100
  } fsq_state_t;

  typedef enum logic [1:0] {
    OPK_PROG   = 2'd0,
    OPK_PERASE = 2'd1,
    OPK_SSE    = 2'd2
  } fsq_op_t;

endpackage

// >>> hw/fsq_link_rx.sv
// Serial-clock side: opcode, address and data capture plus the page buffer
`timescale 1ns/1ps
module fsq_link_rx
  import fsq_pkg::*;
(
  // Link
  input  wire logic             spi_sclk_i,
  input  wire logic             reset_n_i,
  input  wire logic             spi_cs_n_i,
  input  wire logic             spi_d_i,
  // From the reference domain
  input  wire logic             busy_i,
  input  wire logic [7:0]       buf_idx_i,
  // Frame contents, static while select is high
  output fsq_frame_t            frame_o,
  output logic [7:0]            buf_data_o,
  output logic [PAGE_BYTES-1:0] buf_valid_o
);

  logic [7:0]            pbuf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pvalid_reg;
  logic                  first_reg;
  logic [2:0]            busy_sync_reg;
  logic                  busy_filt_reg;
  logic [2:0]            bit_cnt_reg;
  logic [2:0]            nbytes_reg;
  logic [6:0]            sh_reg;
  logic [7:0]            opcode_reg;
  logic [23:0]           addr_reg;
  logic [7:0]            lock_data_reg;
  logic [7:0]            dptr_reg;
  logic                  open_reg;

  // Select high re-arms the frame; the counters keep their values for the other domain
  wire       frame_rst  = spi_cs_n_i | ~reset_n_i;
  wire [2:0] bit_cur    = first_reg ? 3'd0 : bit_cnt_reg;
  wire [2:0] nb_cur     = first_reg ? 3'd0 : nbytes_reg;
  wire [7:0] dptr_cur   = first_reg ? 8'h00 : dptr_reg;
  wire [7:0] byte_in    = {sh_reg, spi_d_i};
  wire       byte_done  = bit_cur == BIT_LAST;
  wire       is_data    = nb_cur >= NB_ADDR;
  wire       op_done    = byte_done && nb_cur == 3'd0;
  wire       addr_byte  = byte_done && nb_cur != 3'd0 && nb_cur < NB_ADDR;
  wire       data_wr    = byte_done && is_data && open_reg;
  wire [7:0] wpos       = addr_reg[7:0] + dptr_cur;
  wire [2:0] nb_next    = (byte_done && nb_cur != NB_MAX) ? nb_cur + 3'd1 : nb_cur;

  always_ff @(posedge spi_sclk_i or posedge frame_rst) begin
    if (frame_rst) first_reg <= 1'b1;
    else           first_reg <= 1'b0;
  end

  always_ff @(posedge spi_sclk_i or negedge reset_n_i) begin
    if (!reset_n_i) busy_sync_reg <= 3'b000;
    else            busy_sync_reg <= {busy_sync_reg[1:0], busy_i};
  end

  // Busy only counts once the last two stages agree
  always_ff @(posedge spi_sclk_i or negedge reset_n_i) begin
    if (!reset_n_i)                              busy_filt_reg <= 1'b0;
    else if (busy_sync_reg[1] == busy_sync_reg[2]) busy_filt_reg <= busy_sync_reg[2];
  end

  always_ff @(posedge spi_sclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bit_cnt_reg <= 3'd0;
      nbytes_reg  <= 3'd0;
      sh_reg      <= 7'h00;
      dptr_reg    <= 8'h00;
    end else begin
      bit_cnt_reg <= bit_cur + 3'd1;
      nbytes_reg  <= nb_next;
      sh_reg      <= byte_in[6:0];
      dptr_reg    <= dptr_cur + {7'h00, byte_done & is_data};
    end
  end

  always_ff @(posedge spi_sclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      opcode_reg    <= 8'h00;
      addr_reg      <= 24'h000000;
      lock_data_reg <= 8'h00;
      open_reg      <= 1'b0;
    end else begin
      if (op_done) opcode_reg <= byte_in;
      if (op_done) open_reg <= ~busy_filt_reg;
      if (addr_byte) addr_reg <= {addr_reg[15:0], byte_in};
      if (byte_done && nb_cur == NB_ADDR) lock_data_reg <= byte_in;
    end
  end

  // Buffer is only opened when no cycle runs, so a running program reads stable bytes
  always_ff @(posedge spi_sclk_i or negedge reset_n_i) begin
    if (!reset_n_i)                    pvalid_reg <= '0;
    else if (op_done && !busy_filt_reg) pvalid_reg <= '0;
    else if (data_wr)                  pvalid_reg[wpos] <= 1'b1;
  end

  always_ff @(posedge spi_sclk_i) begin
    if (data_wr) pbuf[wpos] <= byte_in;
  end

  assign frame_o.opcode    = opcode_reg;
  assign frame_o.addr      = addr_reg;
  assign frame_o.nbytes    = nbytes_reg;
  // Select high sets the re-arm flag at once, so alignment must not look at it
  assign frame_o.aligned   = bit_cnt_reg == 3'd0;
  assign frame_o.open      = open_reg;
  assign frame_o.lock_data = lock_data_reg;
  assign buf_data_o        = pbuf[buf_idx_i];
  assign buf_valid_o       = pvalid_reg;

endmodule // fsq_link_rx

// >>> hw/fsq_top.sv
// Serial flash program, lock-write and erase sequencer with its array
// Operation
// - Programming only clears bits, never sets them
// - Commands need write-enable latch set beforehand
// - Data past page end wraps within page
// - Over 256 bytes: last 256 kept
// - Only bytes actually sent get programmed
// - Program runs only on byte-aligned select rise
// - Select rise starts cycle; busy flag shows it
// - Write-enable latch clears before cycle ends
// - Hardware-protected sector is never programmed or erased
// - Commands during running cycle are rejected
// - Lock write: address, one byte, aligned rise
// - Lock bits immediate; latch clears in the same cycle
// - Page erase sets whole addressed page
// - Erase runs only if select rises after address
// - Subsector erase sets whole addressed subsector
// - Protected subsector is never erased
// - Reset aborts erase and enters reset mode
// - Address bits 23 to 19 ignored
`timescale 1ns/1ps
module fsq_top
  import fsq_pkg::*;
#(
  parameter int unsigned PROG_CYC   = PROG_CYC_DEF,
  parameter int unsigned PERASE_CYC = PERASE_CYC_DEF,
  parameter int unsigned SSE_CYC    = SSE_CYC_DEF
)(
  // System
  input  wire logic              ref_clk_i,
  input  wire logic              reset_n_i,
  // Serial link
  input  wire logic              spi_sclk_i,
  input  wire logic              spi_cs_n_i,
  input  wire logic              spi_d_i,
  // Hardware protection, one bit per sector
  input  wire logic [NUM_SECT-1:0] hw_prot_i,
  // Array read-back
  input  wire logic [ADDR_W-1:0] mem_rd_addr_i,
  output logic [7:0]             mem_rd_data_o,
  // Status
  output logic                   write_in_progress_o,
  output logic                   write_enable_latch_o,
  output fsq_lock_t [NUM_SECT-1:0] sector_lock_o,
  output fsq_result_t            cmd_result_o
);

  logic [7:0]            mem [MEM_BYTES];
  logic [2:0]            cs_sync_reg;
  logic                  cs_filt_reg;
  fsq_state_t            st_reg;
  fsq_state_t            st_next;
  fsq_op_t               op_reg;
  logic [SUB_W-1:0]      idx_reg;
  logic [TMR_W-1:0]      tmr_reg;
  logic [ADDR_W-1:0]     base_reg;
  logic                  wip_reg;
  logic                  wel_reg;
  fsq_lock_t [NUM_SECT-1:0] sector_lock_bits_reg;
  fsq_result_t           result_reg;
  logic [7:0]            rd_data_reg;
  fsq_frame_t            fr;
  logic [7:0]            buf_data;
  logic [PAGE_BYTES-1:0] buf_valid;

  // Frame capture runs on the link clock
  fsq_link_rx u_link_rx (
    .spi_sclk_i  (spi_sclk_i),
    .reset_n_i   (reset_n_i),
    .spi_cs_n_i  (spi_cs_n_i),
    .spi_d_i     (spi_d_i),
    .busy_i      (wip_reg),
    .buf_idx_i   (idx_reg[7:0]),
    .frame_o     (fr),
    .buf_data_o  (buf_data),
    .buf_valid_o (buf_valid)
  );

  // Select synchroniser; the frame fields are static once select has gone high
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) cs_sync_reg <= 3'b111;
    else            cs_sync_reg <= {cs_sync_reg[1:0], spi_cs_n_i};
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i)                          cs_filt_reg <= 1'b1;
    else if (cs_sync_reg[1] == cs_sync_reg[2]) cs_filt_reg <= cs_sync_reg[1];
  end

  // Command ends only when select rises; host keeps it low meanwhile
  wire cs_rise = cs_sync_reg[1] & cs_sync_reg[2] & ~cs_filt_reg;

  // Decode of the finished frame
  wire [SECT_W-1:0] sect = fr.addr[SECT_LSB +: SECT_W];
  wire sw_lock   = sector_lock_bits_reg[sect].wlock;
  wire hw_lock   = hw_prot_i[sect];
  wire locked    = hw_lock | sw_lock;

  wire is_write_enable_cmd   = fr.opcode == OPC_WRITE_ENABLE;
  wire is_prog   = fr.opcode == OPC_PROGRAM_PAGE;
  wire is_lock   = fr.opcode == OPC_LOCK_WRITE;
  wire is_pe     = fr.opcode == OPC_ERASE_PAGE;
  wire is_sse    = fr.opcode == OPC_ERASE_SUB;
  wire is_write  = is_prog | is_lock | is_pe | is_sse;

  wire fmt_write_enable_cmd  = fr.aligned && fr.nbytes == NB_OPCODE;
  wire fmt_prog  = fr.aligned && fr.nbytes >= NB_DATA1 && fr.open;
  wire fmt_lock  = fr.aligned && fr.nbytes == NB_DATA1;
  wire fmt_erase = fr.aligned && fr.nbytes == NB_ADDR;
  wire fmt_ok    = (is_prog & fmt_prog) | (is_lock & fmt_lock)
                 | ((is_pe | is_sse) & fmt_erase);

  wire needs_lock_chk = is_prog | is_pe | is_sse;
  wire can_start = cs_rise & wel_reg & ~wip_reg;

  wire write_enable_cmd_hit  = cs_rise & ~wip_reg & is_write_enable_cmd & fmt_write_enable_cmd;
  wire prog_hit  = can_start & is_prog & fmt_prog & ~locked;
  wire pe_hit    = can_start & is_pe & fmt_erase & ~locked;
  wire sse_hit   = can_start & is_sse & fmt_erase & ~locked;
  wire lock_hit  = can_start & is_lock & fmt_lock;
  wire go        = prog_hit | pe_hit | sse_hit;

  wire [TMR_W-1:0] tmr_load =
    prog_hit ? TMR_W'(PROG_CYC) :
    pe_hit   ? TMR_W'(PERASE_CYC) : TMR_W'(SSE_CYC);

  wire fsq_op_t op_load = prog_hit ? OPK_PROG : (pe_hit ? OPK_PERASE : OPK_SSE);

  // Page or subsector base; any address inside selects it
  wire [ADDR_W-1:0] page_base = {fr.addr[ADDR_W-1:PAGE_W], {PAGE_W{1'b0}}};
  wire [ADDR_W-1:0] sub_base  = {fr.addr[ADDR_W-1:SUB_W], {SUB_W{1'b0}}};
  wire [ADDR_W-1:0] base_load = sse_hit ? sub_base : page_base;

  // Walk through the target bytes
  wire [SUB_W-1:0]  idx_last  = (op_reg == OPK_SSE) ? SUB_LAST : PAGE_LAST;
  wire              work_end  = idx_reg == idx_last;
  wire [ADDR_W-1:0] work_addr = base_reg | ADDR_W'(idx_reg);
  wire              is_prog_op = op_reg == OPK_PROG;
  wire              byte_sent = buf_valid[idx_reg[7:0]];
  wire              mem_we    = st_reg == ST_WORK && (!is_prog_op || byte_sent);
  wire [7:0]        mem_old   = mem[work_addr];
  wire [7:0]        mem_wdata = is_prog_op ? (mem_old & buf_data) : BYTE_ERASED;
  wire              tmr_zero  = tmr_reg == '0;

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      ST_IDLE: begin
        if (go) st_next = ST_WORK;
      end
      ST_WORK: begin
        if (work_end) st_next = ST_WAIT;
      end
      ST_WAIT: begin
        if (tmr_zero) st_next = ST_IDLE;
      end
      default: begin
        st_next = ST_IDLE;
      end
    endcase
  end

  // Reset low drops any running cycle; the array keeps whatever was done
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg  <= ST_IDLE;
      wip_reg <= 1'b0;
    end else begin
      st_reg  <= st_next;
      wip_reg <= st_next != ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      op_reg   <= OPK_PROG;
      base_reg <= '0;
    end else if (go) begin
      op_reg   <= op_load;
      base_reg <= base_load;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i)              idx_reg <= '0;
    else if (go)                 idx_reg <= '0;
    else if (st_reg == ST_WORK)  idx_reg <= idx_reg + 12'h001;
  end

  // The cycle time counts from the start, the byte walk runs inside it
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i)     tmr_reg <= '0;
    else if (go)        tmr_reg <= tmr_load;
    else if (!tmr_zero) tmr_reg <= tmr_reg - 24'h000001;
  end

  // Write-enable latch: cleared at cycle start, well before the cycle ends
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i)           wel_reg <= 1'b0;
    else if (write_enable_cmd_hit)        wel_reg <= 1'b1;
    else if (go || lock_hit)  wel_reg <= 1'b0;
  end

  // Lock bits are volatile and change at once; lock-down freezes them
  genvar g;
  generate
    for (g = 0; g < NUM_SECT; g++) begin : g_lock
      wire hit = lock_hit && sect == SECT_W'(g) && !sector_lock_bits_reg[g].down;
      always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) sector_lock_bits_reg[g] <= '0;
        else if (hit)   sector_lock_bits_reg[g] <= fr.lock_data[LOCK_DOWN_BIT:LOCK_WR_BIT];
      end
    end
  endgenerate

  // Outcome of the last write-class command, for software polling
  wire fsq_result_t result_next = '{
    accepted: go | lock_hit,
    busy:     wip_reg,
    no_wel:   ~wel_reg,
    protect:  needs_lock_chk & locked,
    framing:  ~fmt_ok
  };

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i)               result_reg <= '0;
    else if (cs_rise && is_write) result_reg <= result_next;
  end

  // Array is not reset: an aborted erase leaves partial contents
  always_ff @(posedge ref_clk_i) begin
    if (mem_we) mem[work_addr] <= mem_wdata;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) rd_data_reg <= 8'h00;
    else            rd_data_reg <= mem[mem_rd_addr_i];
  end

  assign mem_rd_data_o        = rd_data_reg;
  assign write_in_progress_o  = wip_reg;
  assign write_enable_latch_o = wel_reg;
  assign sector_lock_o        = sector_lock_bits_reg;
  assign cmd_result_o         = result_reg;

endmodule // fsq_top

// >>> verif/fsq_host.sv
// Serial host model: select, link clock and data
`timescale 1ns/1ps
module fsq_host (
  // Link
  output logic sclk_o,
  output logic cs_n_o,
  output logic d_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    d_o    = 1'b0;
  end

  // Clock runs only inside a frame; 12 ns period
  task automatic send(input logic [7:0] q[$], input int nb);
    cs_n_o = 1'b0;
    #7;
    for (int i = 0; i < nb; i++) begin
      d_o = q[i/8][7-(i%8)];
      #6 sclk_o = 1'b1;
      #6 sclk_o = 1'b0;
    end
    #5 cs_n_o = 1'b1;
    // Released line shows the inverse so a stale bit is never mistaken for data
    d_o = ~d_o;
    #150;
  endtask
endmodule // fsq_host

// >>> verif/fsq_props.sv
// Concurrent checks on the sequencer's top-level ports
`timescale 1ns/1ps
module fsq_props
  import fsq_pkg::*;
#(
  parameter int unsigned PROG_CYC   = PROG_CYC_DEF,
  parameter int unsigned PERASE_CYC = PERASE_CYC_DEF,
  parameter int unsigned SSE_CYC    = SSE_CYC_DEF
)(
  input wire logic                    ref_clk_i,
  input wire logic                    reset_n_i,
  input wire logic                    spi_sclk_i,
  input wire logic                    spi_cs_n_i,
  input wire logic                    spi_d_i,
  input wire logic [NUM_SECT-1:0]     hw_prot_i,
  input wire logic [ADDR_W-1:0]       mem_rd_addr_i,
  input wire logic [7:0]              mem_rd_data_o,
  input wire logic                    write_in_progress_o,
  input wire logic                    write_enable_latch_o,
  input wire fsq_lock_t [NUM_SECT-1:0] sector_lock_o,
  input wire fsq_result_t             cmd_result_o
);
  localparam int unsigned PE_MIN  = (PROG_CYC < PERASE_CYC) ? PROG_CYC : PERASE_CYC;
  localparam int unsigned CYC_MIN = (PE_MIN < SSE_CYC) ? PE_MIN : SSE_CYC;
  logic [31:0] wip_cnt;

  // Length of the current busy period in reference cycles
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) wip_cnt <= '0;
    else if (write_in_progress_o) wip_cnt <= wip_cnt + 32'h1;
    else wip_cnt <= '0;
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  property p_start_after_cs;
    $rose(write_in_progress_o) |->
      spi_cs_n_i && $past(spi_cs_n_i, 3) && !$past(spi_cs_n_i, 8);
  endproperty
  a_start_after_cs: assert property (p_start_after_cs)
    else $error("cycle started without a select rise");

  property p_accept;
    $rose(write_in_progress_o) |-> ##[0:1] cmd_result_o.accepted;
  endproperty
  a_accept: assert property (p_accept)
    else $error("cycle started without an accepted command");

  property p_wip_len;
    $fell(write_in_progress_o) |-> wip_cnt >= CYC_MIN;
  endproperty
  a_wip_len: assert property (p_wip_len)
    else $error("self-timed cycle too short");

  property p_needs_wel;
    $rose(write_in_progress_o) |-> $past(write_enable_latch_o, 3);
  endproperty
  a_needs_wel: assert property (p_needs_wel)
    else $error("cycle started with latch clear");

  property p_wel_clear_end;
    $fell(write_in_progress_o) |-> !write_enable_latch_o;
  endproperty
  a_wel_clear_end: assert property (p_wel_clear_end)
    else $error("latch still set at cycle end");

  property p_busy_keeps;
    $rose(cmd_result_o.busy) |-> write_in_progress_o && !cmd_result_o.accepted;
  endproperty
  a_busy_keeps: assert property (p_busy_keeps)
    else $error("command during cycle not refused");

  property p_wel_moves;
    $changed(write_enable_latch_o) |-> spi_cs_n_i && $past(spi_cs_n_i, 3);
  endproperty
  a_wel_moves: assert property (p_wel_moves)
    else $error("latch moved inside a frame");

  property p_lock_quiet;
    $changed(sector_lock_o) |->
      !write_in_progress_o && !write_enable_latch_o && spi_cs_n_i;
  endproperty
  a_lock_quiet: assert property (p_lock_quiet)
    else $error("lock bits changed with latch set or cycle running");

  property p_lock_down(s);
    sector_lock_o[s].down |=> $stable(sector_lock_o[s]);
  endproperty
  for (genvar s = 0; s < NUM_SECT; s++) begin : g_dn
    a_lock_down: assert property (p_lock_down(s))
      else $error("locked-down sector changed");
  end

  c_cycle: cover property ($rose(write_in_progress_o));
  c_busy: cover property ($rose(cmd_result_o.busy));
  c_prot: cover property ($rose(cmd_result_o.protect));
  c_lock: cover property ($changed(sector_lock_o));
endmodule // fsq_props

bind fsq_top fsq_props #(
  .PROG_CYC(PROG_CYC), .PERASE_CYC(PERASE_CYC), .SSE_CYC(SSE_CYC)
) u_props (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .spi_sclk_i(spi_sclk_i),
  .spi_cs_n_i(spi_cs_n_i), .spi_d_i(spi_d_i), .hw_prot_i(hw_prot_i),
  .mem_rd_addr_i(mem_rd_addr_i), .mem_rd_data_o(mem_rd_data_o),
  .write_in_progress_o(write_in_progress_o),
  .write_enable_latch_o(write_enable_latch_o),
  .sector_lock_o(sector_lock_o), .cmd_result_o(cmd_result_o)
);

// >>> verif/tb_top.sv
// Self-checking bench for the program, lock-write and erase sequencer
`timescale 1ns/1ps
module tb_top;
  import fsq_pkg::*;
  localparam int unsigned PC = 300;
  localparam int unsigned EC = 300;
  localparam int unsigned SC = 4200;
  logic                      ref_clk_i, reset_n_i, sclk, cs_n, sd, write_in_progress, write_enable_latch;
  logic [NUM_SECT-1:0]       hw_prot_i;
  logic [ADDR_W-1:0]         mem_rd_addr_i;
  logic [7:0]                rd_data;
  fsq_lock_t [NUM_SECT-1:0]  locks;
  fsq_result_t               res;
  logic [7:0]                mdl [PAGE_BYTES];
  logic [7:0]                nd[$], dq[$];
  logic [7:0]                pop[3] = '{OPC_ERASE_PAGE, OPC_ERASE_SUB, OPC_PROGRAM_PAGE};
  logic [7:0]                bop[6] = '{8'h02, 8'h02, 8'hdb, 8'hdb, 8'h20, 8'he5};
  int                        bnb[6] = '{35, 32, 31, 40, 33, 48};
  int                        lens[3] = '{40, 260, 3};
  int                        error_cnt = 0;
  int                        n_checks = 0;

  fsq_host u_host (.sclk_o(sclk), .cs_n_o(cs_n), .d_o(sd));
  fsq_top #(.PROG_CYC(PC), .PERASE_CYC(EC), .SSE_CYC(SC)) u_dut (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .spi_sclk_i(sclk),
    .spi_cs_n_i(cs_n), .spi_d_i(sd), .hw_prot_i(hw_prot_i),
    .mem_rd_addr_i(mem_rd_addr_i), .mem_rd_data_o(rd_data),
    .write_in_progress_o(write_in_progress), .write_enable_latch_o(write_enable_latch),
    .sector_lock_o(locks), .cmd_result_o(res));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %0t ns: got %h want %h", $time, s, e);
    end
  endtask

  task automatic results;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic fr(input logic [7:0] op, input logic [23:0] a,
                    input logic [7:0] d[$], input int nb);
    logic [7:0] q[$];
    q = {op, a[23:16], a[15:8], a[7:0]};
    q = {q, d};
    u_host.send(q, nb);
  endtask

  // Write enable first, then the command
  task automatic wfr(input logic [7:0] op, input logic [23:0] a,
                     input logic [7:0] d[$], input int nb);
    fr(OPC_WRITE_ENABLE, '0, nd, 8);
    fr(op, a, d, nb);
  endtask

  task automatic idle;
    for (int i = 0; i < 6000 && write_in_progress !== 1'b0; i++) @(posedge ref_clk_i);
    chk(write_in_progress, 0);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    mem_rd_addr_i <= a;
    repeat (2) @(posedge ref_clk_i);
    #1 d = rd_data;
  endtask

  task automatic chk_page(input logic [ADDR_W-1:0] base);
    logic [7:0] b;
    for (int i = 0; i < PAGE_BYTES; i++) begin
      rd(base + ADDR_W'(i), b);
      chk(b, mdl[i]);
    end
  endtask

  // Last byte sent to an offset wins, then it is ANDed into the array
  function automatic void prog_mdl(input logic [7:0] off, input logic [7:0] d[$]);
    logic [7:0] b [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] hit;
    hit = '0;
    foreach (d[k]) begin
      b[8'(off + k)] = d[k];
      hit[8'(off + k)] = 1'b1;
    end
    for (int i = 0; i < PAGE_BYTES; i++) if (hit[i]) mdl[i] &= b[i];
  endfunction

  initial begin
    ref_clk_i = 1'b0;
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    #2000000;
    error_cnt++;
    results();
  end

  initial begin
    logic [7:0] b, off;
    int s;
    s = $urandom(43375);
    reset_n_i = 1'b0;
    hw_prot_i = '0;
    mem_rd_addr_i = '0;
    repeat (8) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    #1 chk({write_in_progress, write_enable_latch, locks, res}, 0);
    fr(OPC_ERASE_SUB, 24'h0, nd, 32);
    chk({write_in_progress, res}, 6'b000100);
    fr(OPC_WRITE_ENABLE, '0, nd, 8);
    chk(write_enable_latch, 1);
    fr(OPC_ERASE_SUB, 24'hf80123, nd, 32);
    chk({write_in_progress, write_enable_latch, res}, 7'b1010000);
    dq = {8'h00};
    wfr(OPC_PROGRAM_PAGE, 24'h000200, dq, 40);
    chk({write_in_progress, write_enable_latch, res.busy, res.accepted}, 4'b1010);
    idle();
    foreach (mdl[i]) mdl[i] = BYTE_ERASED;
    for (int i = 0; i < 8; i++) begin
      rd(ADDR_W'((i == 0) ? 32'hfff : $urandom % 4096), b);
      chk(b, BYTE_ERASED);
    end
    foreach (lens[j]) begin
      off = 8'($urandom) | 8'he1;
      dq = {};
      repeat (lens[j]) dq.push_back(8'($urandom));
      wfr(OPC_PROGRAM_PAGE, {16'h0002, off}, dq, 32 + 8 * lens[j]);
      chk(res.accepted, 1);
      prog_mdl(off, dq);
      idle();
      chk_page(19'h00200);
    end
    foreach (bop[j]) begin
      wfr(bop[j], 24'h000200, dq, bnb[j]);
      chk({write_in_progress, res.accepted, res.framing}, 3'b001);
    end
    for (int p = 0; p < 2; p++) begin
      @(posedge ref_clk_i) hw_prot_i <= (p == 0) ? 8'h01 : 8'h00;
      if (p == 1) begin
        dq = {8'h01};
        wfr(OPC_LOCK_WRITE, 24'h00ffff, dq, 40);
        chk({write_enable_latch, write_in_progress, locks}, 18'h00001);
      end
      foreach (pop[j]) begin
        wfr(pop[j], 24'h000200, dq, (pop[j] == OPC_PROGRAM_PAGE) ? 40 : 32);
        chk({write_in_progress, res}, 6'b000010);
      end
    end
    chk_page(19'h00200);
    dq = {8'h00};
    wfr(OPC_LOCK_WRITE, 24'h000000, dq, 40);
    wfr(OPC_ERASE_PAGE, 24'h0002a7, nd, 32);
    chk(res.accepted, 1);
    idle();
    foreach (mdl[i]) mdl[i] = BYTE_ERASED;
    chk_page(19'h00200);
    wfr(OPC_ERASE_SUB, 24'h000000, nd, 32);
    repeat (50) @(posedge ref_clk_i);
    reset_n_i <= 1'b0;
    @(posedge ref_clk_i);
    #1 chk({write_in_progress, write_enable_latch}, 0);
    @(posedge ref_clk_i) reset_n_i <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    s = $urandom % NUM_SECT;
    dq = {8'h03};
    wfr(OPC_LOCK_WRITE, {5'h1f, 3'(s), 16'h1234}, dq, 40);
    dq = {8'h00};
    wfr(OPC_LOCK_WRITE, {5'h00, 3'(s), 16'h0000}, dq, 40);
    chk({write_enable_latch, locks[s]}, 3'b011);
    results();
  end
endmodule // tb_top
